// ===== hw/dssf_defs.svh
`ifndef DSSF_DEFS_SVH
`define DSSF_DEFS_SVH

// ==========================================================
// Clock and line timing
// ==========================================================
`define DSSF_CLK_HZ          25000000
`define DSSF_BAUD_LO         9600
`define DSSF_BAUD_HI         19200
`define DSSF_BITS_PER_CHAR   11
`define DSSF_SILENCE_TENTHS  35
`define DSSF_BIT_LO          (`DSSF_CLK_HZ / `DSSF_BAUD_LO)
`define DSSF_BIT_HI          (`DSSF_CLK_HZ / `DSSF_BAUD_HI)
`define DSSF_SIL_LO  (`DSSF_BIT_LO * `DSSF_BITS_PER_CHAR * `DSSF_SILENCE_TENTHS / 10)
`define DSSF_SIL_HI  (`DSSF_BIT_HI * `DSSF_BITS_PER_CHAR * `DSSF_SILENCE_TENTHS / 10)
`define DSSF_INIT_WAIT       2'h3

// ==========================================================
// Addresses and dial settings
// ==========================================================
`define DSSF_DIAL_SCALE      16
`define DSSF_ADDR_BCAST      8'h00
`define DSSF_ADDR_MAX        8'hF7
`define DSSF_DIAL_9600       8'hFE
`define DSSF_DIAL_19200      8'hFF

// ==========================================================
// Function codes and register group bases
// ==========================================================
`define DSSF_FC_RD_OUTFLAG   8'h01
`define DSSF_FC_RD_INFLAG    8'h02
`define DSSF_FC_RD_HOLD      8'h03
`define DSSF_FC_RD_INREG     8'h04
`define DSSF_FC_WR_OUTFLAG   8'h05
`define DSSF_FC_WR_HOLD      8'h06
`define DSSF_FC_DEV_ID       8'h2B
`define DSSF_SUB_DEV_ID      8'h0E
`define DSSF_BASE_OUTFLAG    16'h0FA0
`define DSSF_BASE_INFLAG     16'h0BB8
`define DSSF_BASE_HOLD       16'h07D0
`define DSSF_BASE_INREG      16'h03E8
`define DSSF_BASE_NONE       16'h0000

// ==========================================================
// Receive FIFO
// ==========================================================
`define DSSF_FIFO_DEPTH      16
`define DSSF_FIFO_WIDTH      10

`endif

// ===== hw/dssf_pkg.sv
package dssf_pkg;

	typedef enum logic [1:0] {KIND_DATA, KIND_END, KIND_ERR} dssf_kind_e;

	typedef enum logic [2:0] {
		GRP_OUT_FLAGS,
		GRP_IN_FLAGS,
		GRP_HOLD,
		GRP_IN_REGS,
		GRP_DEV_ID
	} dssf_group_e;

	typedef enum {RX_IDLE, RX_START, RX_BITS} dssf_rx_e;

	typedef enum {P_ADDR, P_FUNC, P_SUB, P_DATA, P_SKIP} dssf_parse_e;

endpackage

// ===== hw/dssf_fifo.sv
`timescale 1ns/100ps

module dssf_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             next_out_valid;
	logic             push;
	logic             load;

	// The output stage is a register so a stalled consumer sees stable data.
	always_comb
	begin
		push = in_valid && in_ready;
		load = (count != '0) && (!out_valid || out_ready);
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = load ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
		next_out_valid = load || (out_valid && !out_ready);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			out_valid <= 1'b0;
			in_ready  <= 1'b1;
			out_data  <= '0;
		end
		else
		begin
			wr_ptr    <= next_wr_ptr;
			rd_ptr    <= next_rd_ptr;
			count     <= next_count;
			out_valid <= next_out_valid;
			in_ready  <= next_count < (AW+1)'(DEPTH);
			if (load)
				out_data <= mem[rd_ptr];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

endmodule

// ===== hw/dssf_front_end.sv
// What this block does
// [R1] Slave address is low dial plus sixteen times high dial, 0 to 255.
// [R2] Dial settings 1 to 247 are ordinary addresses the block answers.
// [R3] Settings 0 and 248 to 255 are reserved, never an ordinary address.
// [R4] Address field zero is broadcast, accepted whatever the dials say.
// [R5] Dials at 254 during reset select 9,600 bits per second.
// [R6] Dials at 255 during reset select 19,200 bits per second.
// [R7] Dials are read for rate only just after reset; address follows later.
// [R8] Chosen rate is kept in non-volatile storage across resets.
// [R9] Characters: start, eight data, even parity, stop; bad parity rejected.
// [R10] Silence of 3.5 characters ends the message; framing restarts.
// [R11] Master keeps 3.5 characters of silence before the next message; the bench master only waits for frame_done before sending the next.
// [R12] Master waits at least 500 ms before retrying a request.
// [R13] Code 01 reads output flags based at 4000.
// [R14] Code 02 reads input flags based at 3000.
// [R15] Code 03 reads holding registers based at 2000.
// [R16] Code 04 reads input registers based at 1000.
// [R17] Code 05 writes an output flag based at 4000.
// [R18] Code 06 writes a holding register based at 2000.
// [R19] Code 43 subcode 14 reads identification information.
// [R20] Only 9,600 and 19,200 bits per second exist.
`timescale 1ns/100ps
`include "dssf_defs.svh"

module dssf_front_end #(
	parameter int SIL_LO = `DSSF_SIL_LO,
	parameter int SIL_HI = `DSSF_SIL_HI
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        rx_line,
	input  wire logic [3:0]  low_address_dial,
	input  wire logic [3:0]  high_address_dial,
	input  wire logic        nv_rate_hi,
	output logic             nv_write,
	output logic             nv_rate_data,
	output logic             rate_hi,
	output logic [7:0]       own_addr,
	output logic             own_addr_valid,
	output logic             cmd_valid,
	output logic [7:0]       cmd_func,
	output logic [2:0]       cmd_group,
	output logic [15:0]      cmd_base,
	output logic             cmd_write,
	output logic             cmd_bcast,
	output logic             dat_valid,
	output logic [7:0]       dat_byte,
	input  wire logic        dat_ready,
	output logic             frame_done,
	output logic             frame_ok,
	output logic             overrun
);

	// ==========================================================
	// Input synchronisers
	// ==========================================================
	logic [1:0] rx_sync;
	logic [7:0] dial_meta;
	logic [7:0] dial_s;
	logic       nv_meta;
	logic       nv_s;

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			rx_sync   <= 2'h3;
			dial_meta <= 8'h00;
			dial_s    <= 8'h00;
			nv_meta   <= 1'b0;
			nv_s      <= 1'b0;
		end
		else
		begin
			rx_sync   <= {rx_sync[0], rx_line};
			dial_meta <= {high_address_dial, low_address_dial};
			dial_s    <= dial_meta;
			nv_meta   <= nv_rate_hi;
			nv_s      <= nv_meta;
		end
	end

	wire logic rx_s = rx_sync[1];

	// ==========================================================
	// Rate selection and address
	// ==========================================================
	logic [1:0] init_cnt;
	logic       init_done;
	logic [1:0] next_init_cnt;
	logic       next_init_done;
	logic       next_rate_hi;
	logic       next_nv_write;
	logic       next_nv_rate_data;
	logic [7:0] dial_addr;
	logic [7:0] next_own_addr;
	logic       next_own_valid;

	always_comb
	begin
		dial_addr = 8'({4'h0, dial_s[3:0]} + 8'(`DSSF_DIAL_SCALE) * {4'h0, dial_s[7:4]}); // [R1]
		next_init_cnt = init_cnt;
		next_init_done = init_done;
		next_rate_hi = rate_hi;
		next_nv_write = 1'b0;
		next_nv_rate_data = nv_rate_data;
		// The rate is taken from the dials once, after the synchronisers have filled.
		if (!init_done)
		begin
			next_init_cnt = init_cnt + 2'h1;
			if (init_cnt == `DSSF_INIT_WAIT)
			begin
				next_init_done = 1'b1; // [R7]
				if (dial_addr == `DSSF_DIAL_9600)
				begin
					next_rate_hi = 1'b0; // [R5]
					next_nv_write = 1'b1; // [R8]
					next_nv_rate_data = 1'b0;
				end
				else if (dial_addr == `DSSF_DIAL_19200)
				begin
					next_rate_hi = 1'b1; // [R6]
					next_nv_write = 1'b1; // [R8]
					next_nv_rate_data = 1'b1;
				end
				else
					next_rate_hi = nv_s; // [R8] [R20]
			end
		end
		next_own_addr = dial_addr;
		next_own_valid = (dial_addr != `DSSF_ADDR_BCAST) && (dial_addr <= `DSSF_ADDR_MAX); // [R2] [R3]
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			init_cnt       <= 2'h0;
			init_done      <= 1'b0;
			rate_hi        <= 1'b0;
			nv_write       <= 1'b0;
			nv_rate_data   <= 1'b0;
			own_addr       <= 8'h00;
			own_addr_valid <= 1'b0;
		end
		else
		begin
			init_cnt       <= next_init_cnt;
			init_done      <= next_init_done;
			rate_hi        <= next_rate_hi;
			nv_write       <= next_nv_write;
			nv_rate_data   <= next_nv_rate_data;
			own_addr       <= next_own_addr;
			own_addr_valid <= next_own_valid;
		end
	end

	// ==========================================================
	// Character receiver and silence timer
	// ==========================================================
	dssf_pkg::dssf_rx_e rx_st;
	dssf_pkg::dssf_rx_e next_rx_st;
	logic [11:0] bit_cnt;
	logic [11:0] next_bit_cnt;
	logic [3:0]  nbit;
	logic [3:0]  next_nbit;
	logic [9:0]  shreg;
	logic [9:0]  next_shreg;
	logic [16:0] sil_cnt;
	logic [16:0] next_sil_cnt;
	logic        pending;
	logic        next_pending;
	logic        next_overrun;
	logic        push;
	logic [9:0]  push_data;
	logic        fifo_in_ready;
	logic [11:0] bit_len;
	logic [16:0] sil_len;

	always_comb
	begin
		bit_len = rate_hi ? 12'(`DSSF_BIT_HI) : 12'(`DSSF_BIT_LO); // [R20]
		sil_len = rate_hi ? 17'(SIL_HI) : 17'(SIL_LO);
		next_rx_st = rx_st;
		next_bit_cnt = bit_cnt;
		next_nbit = nbit;
		next_shreg = shreg;
		next_sil_cnt = 17'h0_0000;
		next_pending = pending;
		push = 1'b0;
		push_data = 10'h000;
		case (rx_st)
			dssf_pkg::RX_IDLE:
			begin
				if (init_done && !rx_s)
				begin
					next_rx_st = dssf_pkg::RX_START;
					next_bit_cnt = bit_len >> 1;
				end
				else if (pending)
				begin
					// Silence is counted from the stop-bit sample, half a bit early.
					next_sil_cnt = sil_cnt + 17'h0_0001;
					if (sil_cnt >= sil_len)
					begin
						push = 1'b1; // [R10]
						push_data = {dssf_pkg::KIND_END, 8'h00};
						next_pending = 1'b0;
					end
				end
			end
			dssf_pkg::RX_START:
			begin
				next_bit_cnt = bit_cnt - 12'h001;
				if (bit_cnt == 12'h000)
				begin
					next_rx_st = rx_s ? dssf_pkg::RX_IDLE : dssf_pkg::RX_BITS;
					next_bit_cnt = bit_len;
					next_nbit = 4'h0;
				end
			end
			dssf_pkg::RX_BITS:
			begin
				next_bit_cnt = bit_cnt - 12'h001;
				if (bit_cnt == 12'h000)
				begin
					next_bit_cnt = bit_len;
					next_shreg = {rx_s, shreg[9:1]};
					next_nbit = nbit + 4'h1;
					if (nbit == 4'h9)
					begin
						next_rx_st = dssf_pkg::RX_IDLE;
						next_pending = 1'b1;
						push = 1'b1;
						// Even parity over data and parity bit; a low stop bit also fails.
						if (^next_shreg[8:0] || !next_shreg[9]) // [R9]
							push_data = {dssf_pkg::KIND_ERR, next_shreg[7:0]};
						else
							push_data = {dssf_pkg::KIND_DATA, next_shreg[7:0]};
					end
				end
			end
			default:
				next_rx_st = dssf_pkg::RX_IDLE;
		endcase
		// A full FIFO drops the word; the consumer learns of it by the overrun pulse.
		next_overrun = push && !fifo_in_ready;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			rx_st   <= dssf_pkg::RX_IDLE;
			bit_cnt <= 12'h000;
			nbit    <= 4'h0;
			shreg   <= 10'h000;
			sil_cnt <= 17'h0_0000;
			pending <= 1'b0;
			overrun <= 1'b0;
		end
		else
		begin
			rx_st   <= next_rx_st;
			bit_cnt <= next_bit_cnt;
			nbit    <= next_nbit;
			shreg   <= next_shreg;
			sil_cnt <= next_sil_cnt;
			pending <= next_pending;
			overrun <= next_overrun;
		end
	end

	// ==========================================================
	// Receive FIFO
	// ==========================================================
	logic       fifo_out_valid;
	logic [9:0] fifo_out_data;

	dssf_fifo #(
		.WIDTH (`DSSF_FIFO_WIDTH),
		.DEPTH (`DSSF_FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   (push_data),
		.out_valid (fifo_out_valid),
		.out_ready (dat_ready),
		.out_data  (fifo_out_data)
	);

	// ==========================================================
	// Message parser and dispatch
	// ==========================================================
	dssf_pkg::dssf_parse_e p_st;
	dssf_pkg::dssf_parse_e next_p_st;
	logic        hit;
	logic        bad;
	logic        got_cmd;
	logic        next_hit;
	logic        next_bad;
	logic        next_got_cmd;
	logic        next_cmd_valid;
	logic [7:0]  next_cmd_func;
	logic [2:0]  next_cmd_group;
	logic [15:0] next_cmd_base;
	logic        next_cmd_write;
	logic        next_cmd_bcast;
	logic        next_dat_valid;
	logic [7:0]  next_dat_byte;
	logic        next_frame_done;
	logic        next_frame_ok;
	logic        pop;
	logic [1:0]  wkind;
	logic [7:0]  wbyte;

	always_comb
	begin
		pop = fifo_out_valid && dat_ready;
		wkind = fifo_out_data[9:8];
		wbyte = fifo_out_data[7:0];
		next_p_st = p_st;
		next_hit = hit;
		next_bad = bad;
		next_got_cmd = got_cmd;
		next_cmd_valid = 1'b0;
		next_cmd_func = cmd_func;
		next_cmd_group = cmd_group;
		next_cmd_base = cmd_base;
		next_cmd_write = cmd_write;
		next_cmd_bcast = cmd_bcast;
		next_dat_valid = 1'b0;
		next_dat_byte = dat_byte;
		next_frame_done = 1'b0;
		next_frame_ok = frame_ok;
		if (pop && wkind == dssf_pkg::KIND_END)
		begin
			next_frame_done = 1'b1; // [R10]
			next_frame_ok = hit && got_cmd && !bad;
			next_p_st = dssf_pkg::P_ADDR;
			next_hit = 1'b0;
			next_bad = 1'b0;
			next_got_cmd = 1'b0;
		end
		else if (pop && wkind == dssf_pkg::KIND_ERR)
			next_bad = 1'b1; // [R9]
		else if (pop)
		begin
			case (p_st)
				dssf_pkg::P_ADDR:
				begin
					next_cmd_bcast = wbyte == `DSSF_ADDR_BCAST; // [R4]
					next_hit = next_cmd_bcast || (own_addr_valid && wbyte == own_addr); // [R2] [R3]
					next_p_st = next_hit ? dssf_pkg::P_FUNC : dssf_pkg::P_SKIP;
				end
				dssf_pkg::P_FUNC:
				begin
					next_cmd_func = wbyte;
					next_p_st = dssf_pkg::P_DATA;
					next_cmd_valid = 1'b1;
					next_got_cmd = 1'b1;
					next_cmd_write = 1'b0;
					case (wbyte)
						`DSSF_FC_RD_OUTFLAG:
						begin
							next_cmd_group = dssf_pkg::GRP_OUT_FLAGS; // [R13]
							next_cmd_base = `DSSF_BASE_OUTFLAG;
						end
						`DSSF_FC_RD_INFLAG:
						begin
							next_cmd_group = dssf_pkg::GRP_IN_FLAGS; // [R14]
							next_cmd_base = `DSSF_BASE_INFLAG;
						end
						`DSSF_FC_RD_HOLD:
						begin
							next_cmd_group = dssf_pkg::GRP_HOLD; // [R15]
							next_cmd_base = `DSSF_BASE_HOLD;
						end
						`DSSF_FC_RD_INREG:
						begin
							next_cmd_group = dssf_pkg::GRP_IN_REGS; // [R16]
							next_cmd_base = `DSSF_BASE_INREG;
						end
						`DSSF_FC_WR_OUTFLAG:
						begin
							next_cmd_group = dssf_pkg::GRP_OUT_FLAGS; // [R17]
							next_cmd_base = `DSSF_BASE_OUTFLAG;
							next_cmd_write = 1'b1;
						end
						`DSSF_FC_WR_HOLD:
						begin
							next_cmd_group = dssf_pkg::GRP_HOLD; // [R18]
							next_cmd_base = `DSSF_BASE_HOLD;
							next_cmd_write = 1'b1;
						end
						`DSSF_FC_DEV_ID:
						begin
							// The command waits for the subcode before it is issued.
							next_cmd_valid = 1'b0;
							next_got_cmd = 1'b0;
							next_p_st = dssf_pkg::P_SUB;
						end
						default:
						begin
							next_cmd_valid = 1'b0;
							next_got_cmd = 1'b0;
							next_bad = 1'b1;
							next_p_st = dssf_pkg::P_SKIP;
						end
					endcase
				end
				dssf_pkg::P_SUB:
				begin
					if (wbyte == `DSSF_SUB_DEV_ID)
					begin
						next_cmd_valid = 1'b1; // [R19]
						next_got_cmd = 1'b1;
						next_cmd_group = dssf_pkg::GRP_DEV_ID;
						next_cmd_base = `DSSF_BASE_NONE;
						next_p_st = dssf_pkg::P_DATA;
					end
					else
					begin
						next_bad = 1'b1;
						next_p_st = dssf_pkg::P_SKIP;
					end
				end
				dssf_pkg::P_DATA:
				begin
					next_dat_valid = 1'b1;
					next_dat_byte = wbyte;
				end
				default:
					next_p_st = dssf_pkg::P_SKIP;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			p_st       <= dssf_pkg::P_ADDR;
			hit        <= 1'b0;
			bad        <= 1'b0;
			got_cmd    <= 1'b0;
			cmd_valid  <= 1'b0;
			cmd_func   <= 8'h00;
			cmd_group  <= 3'h0;
			cmd_base   <= 16'h0000;
			cmd_write  <= 1'b0;
			cmd_bcast  <= 1'b0;
			dat_valid  <= 1'b0;
			dat_byte   <= 8'h00;
			frame_done <= 1'b0;
			frame_ok   <= 1'b0;
		end
		else
		begin
			p_st       <= next_p_st;
			hit        <= next_hit;
			bad        <= next_bad;
			got_cmd    <= next_got_cmd;
			cmd_valid  <= next_cmd_valid;
			cmd_func   <= next_cmd_func;
			cmd_group  <= next_cmd_group;
			cmd_base   <= next_cmd_base;
			cmd_write  <= next_cmd_write;
			cmd_bcast  <= next_cmd_bcast;
			dat_valid  <= next_dat_valid;
			dat_byte   <= next_dat_byte;
			frame_done <= next_frame_done;
			frame_ok   <= next_frame_ok;
		end
	end

endmodule

// ===== dv/dssf_master_model.sv
`timescale 1ns/100ps

module dssf_master_model (
	input  wire logic clk_sys,
	input  wire logic fast,
	output logic      tx_line
);
	// ==========================================
	// Character sender
	// ==========================================
	// The bus is biased to idle high, so the line rests at 1 between characters.
	initial tx_line = 1'b1;

	// Each request goes out once and is never retried, so the retry spacing holds trivially.
	task automatic send_char(input logic [7:0] b);
		logic [10:0] frame;
		int          bit_len;
		frame = {1'b1, ^b, b, 1'b0};
		bit_len = fast ? 1302 : 2604;
		for (int i = 0; i < 11; i++)
		begin
			@(posedge clk_sys);
			tx_line <= frame[i];
			repeat (bit_len - 1) @(posedge clk_sys);
		end
	endtask
endmodule

// ===== dv/dssf_front_end_asserts.sv
`timescale 1ns/100ps
`include "dssf_defs.svh"

module dssf_front_end_asserts (
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic [3:0]  low_address_dial,
	input wire logic [3:0]  high_address_dial,
	input wire logic        nv_rate_hi,
	input wire logic        nv_write,
	input wire logic        nv_rate_data,
	input wire logic        rate_hi,
	input wire logic [7:0]  own_addr,
	input wire logic        own_addr_valid,
	input wire logic        cmd_valid,
	input wire logic [7:0]  cmd_func,
	input wire logic [2:0]  cmd_group,
	input wire logic [15:0] cmd_base,
	input wire logic        cmd_write,
	input wire logic        frame_done
);
	// ==========================================
	// Helpers
	// ==========================================
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic [7:0] dial;
	assign dial = {high_address_dial, low_address_dial};

	function automatic logic map_ok(logic [7:0] f, logic [2:0] g, logic [15:0] b, logic w);
		case (f)
			8'h01: map_ok = g == 3'h0 && b == 16'h0FA0 && !w;
			8'h02: map_ok = g == 3'h1 && b == 16'h0BB8 && !w;
			8'h03: map_ok = g == 3'h2 && b == 16'h07D0 && !w;
			8'h04: map_ok = g == 3'h3 && b == 16'h03E8 && !w;
			8'h05: map_ok = g == 3'h0 && b == 16'h0FA0 && w;
			8'h06: map_ok = g == 3'h2 && b == 16'h07D0 && w;
			8'h2B: map_ok = g == 3'h4 && !w;
			default: map_ok = 1'b0;
		endcase
	endfunction

	// A dial value that has settled through the synchroniser.
	// Reset must be out as well, since the synchroniser holds zero while in reset.
	sequence s_steady;
		(rstn && $stable(dial))[*4];
	endsequence
	sequence s_fresh;
		$rose(rstn);
	endsequence
	sequence s_settled;
		rstn[*8];
	endsequence

	// ==========================================
	// Properties
	// ==========================================
	a_addr_sum: assert property (s_steady |-> own_addr == dial)
		else $error("own address is not the dial sum");
	a_addr_valid: assert property (s_steady |->
		own_addr_valid == (dial != 8'h00 && dial <= 8'hF7))
		else $error("address valid flag wrong");
	a_rate_slow: assert property (s_fresh ##0 (dial == 8'hFE) |-> ##6 !rate_hi)
		else $error("dial 254 did not select the slow rate");
	a_rate_fast: assert property (s_fresh ##0 (dial == 8'hFF) |-> ##6 rate_hi)
		else $error("dial 255 did not select the fast rate");
	a_rate_kept: assert property (s_fresh ##0 (dial != 8'hFE && dial != 8'hFF)
		|-> ##6 (rate_hi == nv_rate_hi))
		else $error("stored rate not restored");
	a_nv_store: assert property (s_fresh ##0 (dial == 8'hFF)
		|-> ##[1:6] (nv_write && nv_rate_data))
		else $error("fast rate not stored");
	a_rate_frozen: assert property (s_settled |=> $stable(rate_hi))
		else $error("rate changed outside reset");
	a_cmd_map: assert property (cmd_valid |->
		map_ok(cmd_func, cmd_group, cmd_base, cmd_write))
		else $error("command group or base wrong");
	// A command may be followed at once by the frame end when the buffer drains a backlog.
	a_cmd_single: assert property (cmd_valid |=> !cmd_valid)
		else $error("command pulse longer than one cycle");
	a_done_single: assert property (frame_done |=> !frame_done)
		else $error("frame end pulse longer than one cycle");
endmodule

bind dssf_front_end dssf_front_end_asserts u_dssf_front_end_asserts (
	.clk_sys, .rstn, .low_address_dial, .high_address_dial, .nv_rate_hi, .nv_write,
	.nv_rate_data, .rate_hi, .own_addr, .own_addr_valid, .cmd_valid, .cmd_func,
	.cmd_group, .cmd_base, .cmd_write, .frame_done
);

// ===== dv/dssf_front_end_tb.sv
`timescale 1ns/100ps
`include "dssf_defs.svh"

module dssf_front_end_tb;
	logic        clk_sys, rstn, nv_rate_hi, dat_ready, rx_line;
	logic [3:0]  low_address_dial, high_address_dial;
	logic        nv_write, nv_rate_data, rate_hi, own_addr_valid, cmd_valid, cmd_write;
	logic [7:0]  own_addr, cmd_func, dat_byte;
	logic [2:0]  cmd_group;
	logic [15:0] cmd_base;
	logic        cmd_bcast, dat_valid, frame_done, frame_ok, overrun, ok_seen;
	int          n_fail, checked, n_cmd, n_done, n_dat, n_ovr;

	// ==========================================
	// Design, far side and store
	// ==========================================
	dssf_front_end #(.SIL_LO(4000), .SIL_HI(2000)) u_dssf_front_end (.clk_sys, .rstn,
		.rx_line, .low_address_dial, .high_address_dial, .nv_rate_hi, .nv_write,
		.nv_rate_data, .rate_hi, .own_addr, .own_addr_valid, .cmd_valid, .cmd_func,
		.cmd_group, .cmd_base, .cmd_write, .cmd_bcast, .dat_valid, .dat_byte, .dat_ready,
		.frame_done, .frame_ok, .overrun);
	dssf_master_model u_dssf_master_model (.clk_sys, .fast(rate_hi), .tx_line(rx_line));

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// The store starts at 1 so that a stored 0 really shows.
	always @(posedge clk_sys)
	begin
		if (nv_write === 1'b1) nv_rate_hi <= nv_rate_data;
		if (cmd_valid === 1'b1) n_cmd++;
		if (dat_valid === 1'b1) n_dat++;
		if (overrun === 1'b1) n_ovr++;
		if (frame_done === 1'b1)
		begin
			n_done++;
			ok_seen <= frame_ok;
		end
	end

	// ==========================================
	// Shared tasks
	// ==========================================
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic set_dial(input logic [7:0] d, input logic rst);
		@(posedge clk_sys);
		rstn <= !rst;
		{high_address_dial, low_address_dial} <= d;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (10) @(posedge clk_sys);
	endtask

	task automatic send_msg(input logic [23:0] b, input int n, input logic stall);
		int d0;
		int k;
		d0 = n_done;
		if (stall)
			dat_ready <= 1'b0;
		for (k = 0; k < n; k++)
			u_dssf_master_model.send_char(b[8*k +: 8]);
		// Stalling past the silence leaves every word and the end marker in the buffer.
		if (stall)
		begin
			repeat (2100) @(posedge clk_sys);
			check("frame_done while stalled", d0, n_done);
			dat_ready <= 1'b1;
		end
		for (k = 0; k < 5000 && n_done == d0; k++) @(posedge clk_sys);
		if (n_done == d0)
		begin
			n_fail++;
			$display("[ERR] frame_done count expected %0d seen %0d", d0 + 1, n_done);
			finish_test();
		end
		// One more edge lets the captured frame result settle.
		@(posedge clk_sys);
	endtask

	// ==========================================
	// Scenarios
	// ==========================================
	task automatic t_address;
		logic [7:0] tbl [5];
		tbl = '{8'h00, 8'h01, 8'hF7, 8'hF8, 8'h12};
		foreach (tbl[i])
		begin
			set_dial(tbl[i], 1'b0);
			check("own_addr", {8'h00, tbl[i]}, {8'h00, own_addr});
			check("own_addr_valid", tbl[i] != 8'h00 && tbl[i] <= 8'hF7, own_addr_valid);
		end
		$display("t_address done");
	endtask

	task automatic t_rate;
		set_dial(8'hFE, 1'b1);
		check("rate_hi slow", 0, rate_hi);
		check("stored slow", 0, nv_rate_hi);
		set_dial(8'hFF, 1'b1);
		check("rate_hi fast", 1, rate_hi);
		set_dial(8'hFE, 1'b0);
		check("rate_hi no reset", 1, rate_hi);
		set_dial(8'h12, 1'b1);
		check("rate_hi restored", 1, rate_hi);
		$display("t_rate done");
	endtask

	task automatic t_own_read;
		int c;
		int dd;
		c = n_cmd;
		dd = n_dat;
		send_msg(24'h00_0312, 2, 1'b0);
		check("cmd count", 1, n_cmd - c);
		check("cmd_func", 8'h03, cmd_func);
		check("cmd_group", 2, cmd_group);
		check("cmd_base", 16'h07D0, cmd_base);
		check("cmd_write", 0, cmd_write);
		check("cmd_bcast", 0, cmd_bcast);
		check("dat count", 0, n_dat - dd);
		check("frame_ok", 1, ok_seen);
		$display("t_own_read done");
	endtask

	task automatic t_bcast_write;
		int c;
		int dd;
		c = n_cmd;
		dd = n_dat;
		send_msg(24'h5A_0600, 3, 1'b0);
		check("cmd count", 1, n_cmd - c);
		check("cmd_func", 8'h06, cmd_func);
		check("cmd_base", 16'h07D0, cmd_base);
		check("cmd_write", 1, cmd_write);
		check("cmd_bcast", 1, cmd_bcast);
		check("dat count", 1, n_dat - dd);
		check("dat_byte", 8'h5A, dat_byte);
		check("frame_ok", 1, ok_seen);
		$display("t_bcast_write done");
	endtask

	task automatic t_reserved;
		set_dial(8'hFD, 1'b0);
		check("own_addr_valid FD", 0, own_addr_valid);
		check("rate_hi FD", 1, rate_hi);
		set_dial(8'h12, 1'b0);
		check("own_addr_valid 12", 1, own_addr_valid);
		$display("t_reserved done");
	endtask

	// The consumer stalls through a message to a reserved address, so the buffer holds it.
	task automatic t_fifo;
		int c;
		c = n_cmd;
		send_msg(24'h00_00F8, 1, 1'b1);
		check("cmd count", 0, n_cmd - c);
		check("frame_ok", 0, ok_seen);
		check("overrun count", 0, n_ovr);
		$display("t_fifo done");
	endtask

	initial
	begin
		rstn = 1'b0;
		{low_address_dial, high_address_dial} = '0;
		{nv_rate_hi, dat_ready} = 2'b11;
		{n_fail, checked, n_cmd, n_done, n_dat, n_ovr, ok_seen} = '0;
		set_dial(8'h12, 1'b1);
		t_address();
		t_rate();
		t_own_read();
		t_bcast_write();
		t_reserved();
		t_fifo();
		finish_test();
	end
endmodule
